// [sap_pkg.sv]
// shared constants for the step attenuator control block
`default_nettype none
package sap_pkg;
    localparam int unsigned WORD_W = 7;
    localparam logic [6:0] ATTN_MAX = 7'h7F;
    localparam logic [6:0] ATTN_ZERO = 7'h00;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned PWRUP_MS = 200;
    localparam int unsigned PWRUP_CYC = (CLK_HZ / 1000) * PWRUP_MS;
    localparam int unsigned STAGE_QDB_W = 8;
    // register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_ATTN = 4'h8;
    localparam logic [3:0] OFS_SHIFT = 4'hC;
    // control register fields
    localparam int unsigned CTRL_SEL_BIT = 0;
    localparam int unsigned CTRL_STROBE_BIT = 1;
    localparam int unsigned CTRL_SRC_BIT = 2;
    localparam int unsigned CTRL_WORD_LSB = 8;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {SAP_POWERUP, SAP_PARALLEL, SAP_SERIAL} sap_mode_t;
endpackage : sap_pkg
`default_nettype wire

// [sap_sync.sv]
// two-flop synchroniser bank for pin inputs
`default_nettype none
module sap_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;
    initial
    begin
        if (WIDTH < 1) $error("width must be at least one");
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_r <= '0;
            dout <= '0;
        end
        else if (ce)
        begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule : sap_sync
`default_nettype wire

// [sap_weight.sv]
// attenuation in quarter-dB from the control word
`default_nettype none
module sap_weight
    import sap_pkg::*;
(
    input wire logic [sap_pkg::WORD_W-1:0] word,
    output logic [sap_pkg::STAGE_QDB_W-1:0] qdb
);
    logic [STAGE_QDB_W-1:0] part [WORD_W+1];
    assign part[0] = '0;
    for (genvar i = 0; i < WORD_W; i++)
    begin : g_stage
        assign part[i+1] = part[i] + (word[i] ? STAGE_QDB_W'(1 << i) : '0);
    end
    assign qdb = part[WORD_W];
endmodule : sap_weight
`default_nettype wire

// [sap_top.sv]
// parallel and serial control of a seven-bit step attenuator
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`default_nettype none
module sap_top
    import sap_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES = sap_pkg::PWRUP_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [sap_pkg::WORD_W-1:0] weighted_control_bits,
    input wire logic latch_strobe,
    input wire logic serial_select,
    input wire logic serial_clock,
    input wire logic serial_bit_input,
    output logic [sap_pkg::WORD_W-1:0] attn_word,
    output logic [sap_pkg::STAGE_QDB_W-1:0] attn_qdb,
    output logic powerup_done,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    initial
    begin
        if (PWRUP_CYCLES < 1) $error("power-up count must be at least one");
        if (CTRL_WORD_LSB + WORD_W > 32) $error("control word field overruns the register");
        if (STAGE_QDB_W <= WORD_W) $error("quarter-dB output too narrow for full range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [WORD_W+3:0] pin_raw;
    logic [WORD_W+3:0] pin_s;
    assign pin_raw = {serial_bit_input, serial_clock, serial_select, latch_strobe,
                      weighted_control_bits};
    // serial clock passes the same flops, so its edge is seen late but clean
    sap_sync #(.WIDTH(WORD_W + 4)) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .din(pin_raw),
        .dout(pin_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // software control register
    logic [31:0] ctrl_r;
    logic sw_src;
    assign sw_src = ctrl_r[CTRL_SRC_BIT];
    // software may override the word, strobe and select pins (not the serial clock or data), useful where no controller is wired
    wire logic [WORD_W-1:0] par_bits = sw_src ? ctrl_r[CTRL_WORD_LSB +: WORD_W]
                                              : pin_s[WORD_W-1:0];
    wire logic strobe = sw_src ? ctrl_r[CTRL_STROBE_BIT] : pin_s[WORD_W];
    wire logic sel_serial = sw_src ? ctrl_r[CTRL_SEL_BIT] : pin_s[WORD_W+1];
    wire logic sclk = pin_s[WORD_W+2];
    wire logic sdat = pin_s[WORD_W+3];

    ////////////////////////////////////////////////////////////////////////////
    // power-up timer and mode
    localparam int unsigned CNT_W = $clog2(PWRUP_CYCLES + 1);
    logic [CNT_W-1:0] pwr_cnt_r;
    sap_mode_t mode_r;
    sap_mode_t mode_nxt;
    logic sclk_d_r;
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;
    logic [WORD_W-1:0] attn_nxt;
    wire logic pwr_end = (pwr_cnt_r == CNT_W'(PWRUP_CYCLES - 1));
    wire logic sclk_rise = sclk & ~sclk_d_r;

    // pins are not obeyed until the wait ends; the switches sit at maximum
    // select picks the mode
    assign mode_nxt = (mode_r == SAP_POWERUP && !pwr_end) ? SAP_POWERUP :
                      (sel_serial ? SAP_SERIAL : SAP_PARALLEL);

    // serial pins unused in parallel mode
    assign shift_nxt = (mode_r == SAP_SERIAL && !strobe && sclk_rise) ?
                       {shift_r[WORD_W-2:0], sdat} : shift_r;

    always_comb
    begin
        attn_nxt = attn_word;
        case (mode_r)
            SAP_POWERUP:
            begin
                if (pwr_end && strobe)
                    attn_nxt = par_bits;
                else
                    attn_nxt = ATTN_MAX;
            end
            SAP_PARALLEL:
            begin
                if (strobe)
                    attn_nxt = par_bits;
            end
            SAP_SERIAL:
            begin
                if (strobe)
                    attn_nxt = shift_r;
            end
            default:
            begin
                attn_nxt = ATTN_MAX;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwr_cnt_r <= '0;
            mode_r <= SAP_POWERUP;
            sclk_d_r <= 1'b0;
            shift_r <= ATTN_ZERO;
            attn_word <= ATTN_MAX;
            powerup_done <= 1'b0;
        end
        else if (ce)
        begin
            if (mode_r == SAP_POWERUP)
                pwr_cnt_r <= pwr_cnt_r + CNT_W'(1);
            mode_r <= mode_nxt;
            sclk_d_r <= sclk;
            shift_r <= shift_nxt;
            attn_word <= attn_nxt;
            powerup_done <= (mode_nxt != SAP_POWERUP);
        end
    end

    logic [STAGE_QDB_W-1:0] qdb_w;
    // fed from the next word so qdb and word change on the same edge
    sap_weight u_weight (
        .word(attn_nxt),
        .qdb(qdb_w)
    );
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            attn_qdb <= STAGE_QDB_W'(127);
        else if (ce)
            attn_qdb <= qdb_w;
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave; write address and data may come in either order
    logic aw_got_r;
    logic w_got_r;
    logic [3:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    wire logic aw_hs = s_axi_awvalid & s_axi_awready;
    wire logic w_hs = s_axi_wvalid & s_axi_wready;
    wire logic aw_have = aw_got_r | aw_hs;
    wire logic w_have = w_got_r | w_hs;
    wire logic [3:0] wr_addr = aw_hs ? s_axi_awaddr : awaddr_r;
    wire logic [31:0] wr_data = w_hs ? s_axi_wdata : wdata_r;
    wire logic [3:0] wr_strb = w_hs ? s_axi_wstrb : wstrb_r;
    wire logic wr_fire = aw_have & w_have & ~s_axi_bvalid;
    wire logic wr_ctrl = wr_fire & (wr_addr == OFS_CTRL);
    // other mapped offsets answer okay and keep nothing
    wire logic wr_ok = (wr_addr == OFS_CTRL) | (wr_addr == OFS_STATUS) |
                       (wr_addr == OFS_ATTN) | (wr_addr == OFS_SHIFT);
    logic [31:0] ctrl_nxt;
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        for (int b = 0; b < 4; b++)
            if (wr_ctrl && wr_strb[b])
                ctrl_nxt[8*b +: 8] = wr_data[8*b +: 8];
        // reserved bits always read back as zero
        ctrl_nxt[31:CTRL_WORD_LSB+WORD_W] = '0;
        ctrl_nxt[CTRL_WORD_LSB-1:CTRL_SRC_BIT+1] = '0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 4'h0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            ctrl_r <= CTRL_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (aw_hs)
                awaddr_r <= s_axi_awaddr;
            if (w_hs)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            aw_got_r <= aw_have & ~wr_fire;
            w_got_r <= w_have & ~wr_fire;
            // readies pulse for one cycle, so a held valid is taken only once
            s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
            s_axi_wready <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
            ctrl_r <= ctrl_nxt;
            if (wr_fire)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // status shows the live mode so software can poll the power-up end
    wire logic ar_hs = s_axi_arvalid & s_axi_arready;
    wire logic [31:0] status_word = {27'h0000000, sel_serial, strobe, mode_r, powerup_done};
    // unmapped offsets read as zero with an error response
    logic [31:0] rd_mux;
    logic rd_ok;
    always_comb
    begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            OFS_CTRL: rd_mux = ctrl_r;
            OFS_STATUS: rd_mux = status_word;
            OFS_ATTN: rd_mux = {17'h00000, attn_qdb, attn_word};
            OFS_SHIFT: rd_mux = {25'h0000000, shift_r};
            default:
            begin
                rd_mux = 32'h00000000;
                rd_ok = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (ce)
        begin
            // one read in flight: arready stays low while the answer waits
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & ~s_axi_arvalid ? 1'b0 :
                             ~s_axi_rvalid & ~s_axi_arready;
            if (ar_hs)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end
endmodule : sap_top
`default_nettype wire

// [sap_checker.sv]
// assertions on the attenuator control ports
`default_nettype none
module sap_checker
    import sap_pkg::*;
#(
    parameter int unsigned PWRUP_CYCLES = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [sap_pkg::WORD_W-1:0] weighted_control_bits,
    input wire logic latch_strobe,
    input wire logic serial_select,
    input wire logic [sap_pkg::WORD_W-1:0] attn_word,
    input wire logic [sap_pkg::STAGE_QDB_W-1:0] attn_qdb,
    input wire logic powerup_done,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    int unsigned cnt_r;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////
    // cycles spent waiting for power-up end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cnt_r <= 0;
        else if (ce && !powerup_done)
            cnt_r <= cnt_r + 1;
    end
    AST_PWRUP_MAX: assert property (!powerup_done |-> attn_word == ATTN_MAX)
        else $error("word not at maximum before power-up end");
    // the power-up timer takes no pins, so the wait is exact; still allow a small window around the count
    AST_PWRUP_TIME: assert property ($rose(powerup_done) |->
        cnt_r >= PWRUP_CYCLES - 1 && cnt_r <= PWRUP_CYCLES + 2)
        else $error("power-up wait of wrong length");
    AST_DONE_STAYS: assert property (powerup_done |=> powerup_done)
        else $error("power-up flag dropped");
    AST_WEIGHT_SUM: assert property ($stable(attn_word) [*2] |->
        attn_qdb == {1'b0, attn_word})
        else $error("attenuation not the sum of stage weights");
    AST_LATCH_HOLD: assert property ((!latch_strobe) [*5] |-> $stable(attn_word))
        else $error("word changed while strobe low");
    AST_DIRECT: assert property ((ce && powerup_done && latch_strobe && !serial_select
        && $stable(weighted_control_bits)) [*4] |-> attn_word == weighted_control_bits)
        else $error("direct mode word does not follow inputs");
    AST_BRESP_ONCE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    AST_RDATA_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
endmodule : sap_checker
bind sap_top sap_checker #(.PWRUP_CYCLES(PWRUP_CYCLES)) i_chk (.aclk, .aresetn, .ce,
    .weighted_control_bits, .latch_strobe, .serial_select, .attn_word, .attn_qdb,
    .powerup_done, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// [sap_host.sv]
// pin-level controller model for the attenuator inputs
`default_nettype none
module sap_host (
    input wire logic aclk,
    output var logic [sap_pkg::WORD_W-1:0] weighted_control_bits,
    output var logic latch_strobe,
    output var logic serial_select,
    output var logic serial_clock,
    output var logic serial_bit_input
);
    timeunit 1ns;
    timeprecision 1ns;
    // strobe low at start so power-up lands on maximum
    initial
    begin
        {weighted_control_bits, latch_strobe, serial_select, serial_clock} = 10'h000;
        serial_bit_input = 1'b0;
    end
    // pins move together on an edge
    task automatic par(input logic [6:0] w, input logic s, input logic m);
        @(posedge aclk);
        weighted_control_bits <= w;
        latch_strobe <= s;
        serial_select <= m;
    endtask : par
    // msb first, clock 4 cycles high and 5 cycles low between bits
    task automatic shift(input logic [6:0] w);
        for (int i = 6; i >= 0; i--)
        begin
            @(posedge aclk);
            serial_bit_input <= w[i];
            repeat (4) @(posedge aclk);
            serial_clock <= 1'b1;
            repeat (4) @(posedge aclk);
            serial_clock <= 1'b0;
        end
        repeat (4) @(posedge aclk);
        // flipped so a stale bit never passes for a fresh one
        serial_bit_input <= ~w[0];
    endtask : shift
endmodule : sap_host
`default_nettype wire

// [step_attenuator_parallel_control_test.sv]
// self-checking bench for the attenuator control block
`default_nettype none
module step_attenuator_parallel_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sap_pkg::*;
    localparam logic [6:0] DIR [5] = '{7'h00, 7'h01, 7'h40, 7'h7F, 7'h3C};
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    wire [6:0] weighted_control_bits, attn_word;
    wire [7:0] attn_qdb;
    wire latch_strobe, serial_select, serial_clock, serial_bit_input, powerup_done;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, rd_r;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic ce = 1'b1;
    logic [3:0] s_axi_wstrb = 4'hF;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int failures = 0;
    int comparisons = 0;
    always #50 aclk = ~aclk;
    sap_host i_host (.aclk, .weighted_control_bits, .latch_strobe, .serial_select,
        .serial_clock, .serial_bit_input);
    sap_top #(.PWRUP_CYCLES(20)) i_dut (.aclk, .aresetn, .ce, .weighted_control_bits,
        .latch_strobe, .serial_select, .serial_clock, .serial_bit_input, .attn_word,
        .attn_qdb, .powerup_done, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        // only the watchdog ends a wait for the answer
        while (!s_axi_bvalid)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        chk("bvalid", 1'b1, s_axi_bvalid);
        chk("bresp", RESP_OKAY, s_axi_bresp);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!s_axi_rvalid)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        rd_r = s_axi_rdata;
        chk("rvalid", 1'b1, s_axi_rvalid);
        chk("rresp", r, s_axi_rresp);
    endtask : rd
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    ////////////////////////////////////////
    // whole run is a few hundred cycles
    initial
    begin
        #300000;
        failures++;
        complete_run();
    end
    initial
    begin
        cyc(6);
        aresetn <= 1'b1;
        cyc(10);
        chk("word", attn_word, ATTN_MAX);
        chk("done", powerup_done, 1'b0);
        cyc(20);
        chk("done", powerup_done, 1'b1);
        chk("word", attn_word, ATTN_MAX);
        i_host.par(7'h55, 1'b0, 1'b0);
        cyc(6);
        chk("word", attn_word, ATTN_MAX);
        i_host.par(7'h55, 1'b1, 1'b0);
        cyc(6);
        chk("word", attn_word, 7'h55);
        chk("qdb", attn_qdb, 8'h55);
        i_host.par(7'h55, 1'b0, 1'b0);
        i_host.par(7'h2A, 1'b0, 1'b0);
        cyc(6);
        chk("word", attn_word, 7'h55);
        foreach (DIR[i])
        begin
            i_host.par(DIR[i], 1'b1, 1'b0);
            cyc(6);
            chk("word", attn_word, DIR[i]);
            chk("qdb", attn_qdb, {1'b0, DIR[i]});
        end
        // clock enable low freezes the whole block
        ce <= 1'b0;
        i_host.par(7'h12, 1'b1, 1'b0);
        cyc(6);
        chk("frozen word", attn_word, 7'h3C);
        ce <= 1'b1;
        cyc(6);
        chk("word", attn_word, 7'h12);
        i_host.par(7'h3C, 1'b1, 1'b0);
        i_host.shift(7'h11);
        chk("word", attn_word, 7'h3C);
        i_host.par(7'h3C, 1'b0, 1'b1);
        i_host.shift(7'h4B);
        chk("word", attn_word, 7'h3C);
        i_host.par(7'h3C, 1'b1, 1'b1);
        cyc(6);
        chk("word", attn_word, 7'h4B);
        i_host.shift(7'h01);
        chk("word", attn_word, 7'h4B);
        rd(OFS_STATUS, RESP_OKAY);
        chk("status done", rd_r[0], 1'b1);
        rd(OFS_ATTN, RESP_OKAY);
        chk("attn reg", rd_r[14:0], {8'h4B, 7'h4B});
        rd(OFS_CTRL, RESP_OKAY);
        chk("ctrl", rd_r, CTRL_RESET);
        wr(OFS_SHIFT, 32'hFFFFFFFF);
        wr(OFS_CTRL, CTRL_RESET);
        // software source: parallel, strobe high, word 2D
        wr(OFS_CTRL, 32'h00002D06);
        cyc(4);
        chk("sw word", attn_word, 7'h2D);
        s_axi_wstrb <= 4'h1;
        wr(OFS_CTRL, 32'h00007F00);
        s_axi_wstrb <= 4'hF;
        rd(OFS_CTRL, RESP_OKAY);
        chk("ctrl lanes", rd_r, 32'h00002D00);
        cyc(4);
        chk("word", attn_word, 7'h4B);
        rd(4'h2, RESP_SLVERR);
        chk("rdata", rd_r, 32'h0);
        aresetn <= 1'b0;
        cyc(3);
        chk("word", attn_word, ATTN_MAX);
        chk("done", powerup_done, 1'b0);
        complete_run();
    end
endmodule : step_attenuator_parallel_control_test
`default_nettype wire
